// ---- logic/cap_report_pkg.sv ----
// Constants for the controller capability report block
//
// Operation
// - Report vendor 24-bit registry identifier, bytes 75:73
// - Byte 76 bit0 flags multiple host links
// - Byte 77 exponent over minimum page; zero unlimited
// - Oversized command aborted with invalid-field status
// - Interleaved metadata counts toward transfer size
// - Admin bit2 only with firmware activate and download
// - Admin bit1 only with media format command
// - Admin bit0 only with security send and receive
// - Byte 258 zero-based outstanding abort limit
// - Byte 259 zero-based outstanding event request limit
// - Byte 260 bits3:1 slot count one to seven
// - Byte 260 bit0 set when slot one read-only
// - Byte 261 log page attributes, bits7:1 reserved
// - Byte 261 bit0 means per-namespace health pages
// - Select bit one returns controller structure, else namespace; this block answers zero bytes for namespace
package cap_report_pkg;

	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFS_VENDOR_ID   = 8'h00;
	localparam logic [7:0] OFS_LINK_XFER   = 8'h04;
	localparam logic [7:0] OFS_ADMIN       = 8'h08;
	localparam logic [7:0] OFS_LIMITS      = 8'h0C;
	localparam logic [7:0] OFS_FW_LOG      = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;
	localparam logic [7:0] OFS_ABORT_COUNT = 8'h1C;

	// ==========================================
	// Field positions inside the registers
	localparam int LX_MULTI_LINK_BIT = 0;
	localparam int LX_EXP_LSB        = 8;
	localparam int LX_PAGE_LSB       = 16;
	localparam int LIM_EVENT_LSB     = 8;
	localparam int FW_SLOTS_LSB      = 1;
	localparam int FW_LOG_BIT        = 8;
	localparam int EV_ABORT_BIT      = 0;
	localparam int EV_IDENT_BIT      = 1;

	// ==========================================
	// Reset values; vendor id value is arbitrary
	localparam logic [23:0] RST_VENDOR_ID = 24'h12_3456;
	localparam logic [7:0]  RST_EXPONENT  = 8'h05;
	localparam logic [3:0]  RST_PAGE_CAP  = 4'h0;
	localparam logic [2:0]  RST_ADMIN     = 3'h7;
	localparam logic [7:0]  RST_ABORT_LIM = 8'h03;
	localparam logic [7:0]  RST_EVENT_LIM = 8'h03;
	localparam logic [2:0]  RST_FW_SLOTS  = 3'h1;

	// ==========================================
	// Which optional admin commands this device implements
	localparam logic IMPL_FW_UPDATE = 1'b1;
	localparam logic IMPL_FORMAT    = 1'b1;
	localparam logic IMPL_SECURITY  = 1'b1;

	// ==========================================
	// Structure byte positions
	localparam logic [9:0] SB_VENDOR_LO = 10'd73;
	localparam logic [9:0] SB_VENDOR_MI = 10'd74;
	localparam logic [9:0] SB_VENDOR_HI = 10'd75;
	localparam logic [9:0] SB_MULTI     = 10'd76;
	localparam logic [9:0] SB_EXPONENT  = 10'd77;
	localparam logic [9:0] SB_ADMIN_LO  = 10'd256;
	localparam logic [9:0] SB_ADMIN_HI  = 10'd257;
	localparam logic [9:0] SB_ABORT     = 10'd258;
	localparam logic [9:0] SB_EVENT     = 10'd259;
	localparam logic [9:0] SB_FIRMWARE  = 10'd260;
	localparam logic [9:0] SB_LOG_ATTR  = 10'd261;

	// ==========================================
	// Command status and transfer sizing
	localparam logic [7:0] STATUS_OK            = 8'h00;
	localparam logic [7:0] STATUS_INVALID_FIELD = 8'h02;
	localparam int         BASE_PAGE_SHIFT      = 12;
	localparam int         SIZE_W               = 34;
	localparam logic [1:0] RESP_OKAY            = 2'b00;
	localparam logic [1:0] RESP_SLVERR          = 2'b10;

endpackage

// ---- logic/capability_report.sv ----
// Capability report block: register slave, identify byte server, transfer size check
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module capability_report
	import cap_report_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// AXI4-Lite slave
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Identify byte port
	input  wire logic        id_req,
	input  wire logic        structure_select,
	input  wire logic [9:0]  id_byte_index,
	output var  logic        id_ack,
	output var  logic        id_is_controller,
	output var  logic [7:0]  id_data,
	// Transfer size check port
	input  wire logic        chk_req,
	input  wire logic [31:0] chk_data_bytes,
	input  wire logic [31:0] chk_meta_bytes,
	input  wire logic        chk_meta_interleaved,
	output var  logic        chk_done,
	output var  logic        chk_abort,
	output var  logic [7:0]  chk_status,
	// Interrupt
	output var  logic        irq
);

	// ==========================================
	// Configuration and state registers
	logic [23:0] vendor_id_reg;
	logic        multi_link_capability_reg;
	logic [7:0]  max_transfer_exponent_reg;
	logic [3:0]  min_page_size_cap_reg;
	logic [2:0]  admin_req_reg;
	logic [7:0]  abort_outstanding_limit_reg;
	logic [7:0]  event_request_outstanding_limit_reg;
	logic [2:0]  fw_slots_reg;
	logic        fw_slot1_ro_reg;
	logic        log_per_ns_reg;
	logic [1:0]  irq_status_reg;
	logic [1:0]  irq_mask_reg;
	logic [15:0] abort_count_reg;

	// AXI channel holding state
	logic        aw_hold_reg;
	logic        w_hold_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;

	// ==========================================
	// Handshake decode
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
	wire [7:0] rd_ofs = {s_axi_araddr[7:2], 2'b00};
	wire rd_hit_upper = |s_axi_araddr[31:8];

	// Write address decode
	wire wr_vendor = do_write & (aw_addr_reg == OFS_VENDOR_ID);
	wire wr_link   = do_write & (aw_addr_reg == OFS_LINK_XFER);
	wire wr_admin  = do_write & (aw_addr_reg == OFS_ADMIN);
	wire wr_limits = do_write & (aw_addr_reg == OFS_LIMITS);
	wire wr_fw     = do_write & (aw_addr_reg == OFS_FW_LOG);
	wire wr_mask   = do_write & (aw_addr_reg == OFS_IRQ_MASK);
	wire wr_mapped = (aw_addr_reg == OFS_VENDOR_ID) | (aw_addr_reg == OFS_LINK_XFER)
		| (aw_addr_reg == OFS_ADMIN) | (aw_addr_reg == OFS_LIMITS) | (aw_addr_reg == OFS_FW_LOG)
		| (aw_addr_reg == OFS_IRQ_STATUS) | (aw_addr_reg == OFS_IRQ_MASK)
		| (aw_addr_reg == OFS_ABORT_COUNT);

	// Byte-lane merge of write data over the current word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================
	// Register views with reserved bits forced to zero
	wire [2:0] admin_view = admin_req_reg & {IMPL_FW_UPDATE, IMPL_FORMAT, IMPL_SECURITY};
	wire [31:0] view_vendor = {8'h00, vendor_id_reg};
	wire [31:0] view_link = {12'h000, min_page_size_cap_reg, max_transfer_exponent_reg,
		7'h00, multi_link_capability_reg};
	wire [31:0] view_admin = {29'h0, admin_view};
	wire [31:0] view_limits = {16'h0000, event_request_outstanding_limit_reg, abort_outstanding_limit_reg};
	wire [31:0] view_fw = {23'h0, log_per_ns_reg, 4'h0, fw_slots_reg, fw_slot1_ro_reg};

	wire [31:0] wv_vendor = merge(view_vendor, w_data_reg, w_strb_reg);
	wire [31:0] wv_link   = merge(view_link, w_data_reg, w_strb_reg);
	wire [31:0] wv_limits = merge(view_limits, w_data_reg, w_strb_reg);
	wire [31:0] wv_fw     = merge(view_fw, w_data_reg, w_strb_reg);
	wire [31:0] wv_admin  = merge(view_admin, w_data_reg, w_strb_reg);
	wire [31:0] wv_mask   = merge({30'h0, irq_mask_reg}, w_data_reg, w_strb_reg);
	// Slot count of zero is illegal, so such a write keeps one slot
	wire [2:0] fw_slots_wr = wv_fw[FW_SLOTS_LSB +: 3];
	wire [2:0] fw_slots_next = (fw_slots_wr == 3'h0) ? 3'h1 : fw_slots_wr;

	// Read mux
	wire rd_mapped = ~rd_hit_upper & ((rd_ofs == OFS_VENDOR_ID) | (rd_ofs == OFS_LINK_XFER)
		| (rd_ofs == OFS_ADMIN) | (rd_ofs == OFS_LIMITS) | (rd_ofs == OFS_FW_LOG)
		| (rd_ofs == OFS_IRQ_STATUS) | (rd_ofs == OFS_IRQ_MASK) | (rd_ofs == OFS_ABORT_COUNT));
	wire [31:0] rd_word =
		rd_hit_upper                  ? 32'h0000_0000 :
		(rd_ofs == OFS_VENDOR_ID)     ? view_vendor :
		(rd_ofs == OFS_LINK_XFER)     ? view_link :
		(rd_ofs == OFS_ADMIN)         ? view_admin :
		(rd_ofs == OFS_LIMITS)        ? view_limits :
		(rd_ofs == OFS_FW_LOG)        ? view_fw :
		(rd_ofs == OFS_IRQ_STATUS)    ? {30'h0, irq_status_reg} :
		(rd_ofs == OFS_IRQ_MASK)      ? {30'h0, irq_mask_reg} :
		(rd_ofs == OFS_ABORT_COUNT)   ? {16'h0000, abort_count_reg} : 32'h0000_0000;
	wire rd_status = ar_take & rd_mapped & (rd_ofs == OFS_IRQ_STATUS);

	// ==========================================
	// Transfer size limit: data plus interleaved metadata against page << exponent
	wire [SIZE_W-1:0] xfer_total = {2'b00, chk_data_bytes}
		+ (chk_meta_interleaved ? {2'b00, chk_meta_bytes} : {SIZE_W{1'b0}});
	wire [8:0] limit_shift = 9'(BASE_PAGE_SHIFT) + {5'h00, min_page_size_cap_reg}
		+ {1'b0, max_transfer_exponent_reg};
	// Shift of SIZE_W-1 or more means no reachable size can exceed it
	wire limit_huge = (limit_shift >= 9'(SIZE_W - 1));
	wire [SIZE_W-1:0] limit_bytes = limit_huge ? {SIZE_W{1'b1}}
		: ({{(SIZE_W-1){1'b0}}, 1'b1} << limit_shift[5:0]);
	wire limit_on = (max_transfer_exponent_reg != 8'h00);
	wire too_big = limit_on & ~limit_huge & (xfer_total > limit_bytes);

	// ==========================================
	// Identify structure byte lookup
	function automatic logic [7:0] struct_byte(input logic [9:0] idx);
		logic [7:0] b;
		b = 8'h00;
		unique case (idx)
			SB_VENDOR_LO: b = vendor_id_reg[7:0];
			SB_VENDOR_MI: b = vendor_id_reg[15:8];
			SB_VENDOR_HI: b = vendor_id_reg[23:16];
			SB_MULTI:     b = {7'h00, multi_link_capability_reg};
			SB_EXPONENT:  b = max_transfer_exponent_reg;
			SB_ADMIN_LO:  b = {5'h00, admin_view};
			SB_ADMIN_HI:  b = 8'h00;
			SB_ABORT:     b = abort_outstanding_limit_reg;
			SB_EVENT:     b = event_request_outstanding_limit_reg;
			SB_FIRMWARE:  b = {4'h0, fw_slots_reg, fw_slot1_ro_reg};
			SB_LOG_ATTR:  b = {7'h00, log_per_ns_reg};
			default:      b = 8'h00;
		endcase
		return b;
	endfunction

	// Namespace structure is served elsewhere; this block answers zero for it.
	// Process, not assign: the lookup reads the field registers directly
	logic [7:0] id_byte_next;
	always_comb id_byte_next = structure_select ? struct_byte(id_byte_index) : 8'h00;

	// Events that feed the sticky status
	wire [1:0] ev_set = {id_req & structure_select, chk_req & too_big};

	// ==========================================
	// AXI write channels: address and data taken in either order
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_hold_reg   <= 1'b1;
				aw_addr_reg   <= (|s_axi_awaddr[31:8]) ? 8'hFF : {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_hold_reg   <= 1'b1;
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// AXI read channel: answer one cycle after the address
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================
	// Capability fields written by software; reserved bits dropped on write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			vendor_id_reg                       <= RST_VENDOR_ID;
			multi_link_capability_reg           <= 1'b0;
			max_transfer_exponent_reg           <= RST_EXPONENT;
			min_page_size_cap_reg               <= RST_PAGE_CAP;
			admin_req_reg                       <= RST_ADMIN;
			abort_outstanding_limit_reg         <= RST_ABORT_LIM;
			event_request_outstanding_limit_reg <= RST_EVENT_LIM;
			fw_slots_reg                        <= RST_FW_SLOTS;
			fw_slot1_ro_reg                     <= 1'b0;
			log_per_ns_reg                      <= 1'b0;
			irq_mask_reg                        <= 2'b00;
		end else begin
			if (wr_vendor) vendor_id_reg <= wv_vendor[23:0];
			if (wr_link) begin
				multi_link_capability_reg <= wv_link[LX_MULTI_LINK_BIT];
				max_transfer_exponent_reg <= wv_link[LX_EXP_LSB +: 8];
				min_page_size_cap_reg     <= wv_link[LX_PAGE_LSB +: 4];
			end
			if (wr_admin) admin_req_reg <= wv_admin[2:0];
			if (wr_limits) begin
				abort_outstanding_limit_reg         <= wv_limits[7:0];
				event_request_outstanding_limit_reg <= wv_limits[LIM_EVENT_LSB +: 8];
			end
			if (wr_fw) begin
				fw_slots_reg    <= fw_slots_next;
				fw_slot1_ro_reg <= wv_fw[0];
				log_per_ns_reg  <= wv_fw[FW_LOG_BIT];
			end
			if (wr_mask) irq_mask_reg <= wv_mask[1:0];
		end
	end

	// ==========================================
	// Sticky status: a read clears it, but a new event in that cycle survives
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_reg  <= 2'b00;
			irq             <= 1'b0;
			abort_count_reg <= 16'h0000;
		end else begin
			irq_status_reg <= (rd_status ? 2'b00 : irq_status_reg) | ev_set;
			irq            <= |(((rd_status ? 2'b00 : irq_status_reg) | ev_set) & irq_mask_reg);
			if (ev_set[EV_ABORT_BIT]) abort_count_reg <= abort_count_reg + 16'h0001;
		end
	end

	// ==========================================
	// Identify and check answers, one cycle after the request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			id_ack           <= 1'b0;
			id_is_controller <= 1'b0;
			id_data          <= 8'h00;
			chk_done         <= 1'b0;
			chk_abort        <= 1'b0;
			chk_status       <= STATUS_OK;
		end else begin
			id_ack <= id_req;
			if (id_req) begin
				id_is_controller <= structure_select;
				id_data          <= id_byte_next;
			end
			chk_done <= chk_req;
			if (chk_req) begin
				chk_abort  <= too_big;
				chk_status <= too_big ? STATUS_INVALID_FIELD : STATUS_OK;
			end
		end
	end

endmodule

`default_nettype wire

// ---- tb/controller_capability_report_chk.sv ----
// Port assertions for the capability report block
`timescale 1ns/1ps
`default_nettype none

module controller_capability_report_chk
	import cap_report_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        id_req,
	input wire logic        structure_select,
	input wire logic [9:0]  id_byte_index,
	input wire logic        id_ack,
	input wire logic        id_is_controller,
	input wire logic [7:0]  id_data,
	input wire logic        chk_req,
	input wire logic [31:0] chk_data_bytes,
	input wire logic [31:0] chk_meta_bytes,
	input wire logic        chk_meta_interleaved,
	input wire logic        chk_done,
	input wire logic        chk_abort,
	input wire logic [7:0]  chk_status
);
	// ==========================================
	// Identify answers
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire ctl = id_req && structure_select;
	a_id_answer: assert property (id_req |=> id_ack && id_is_controller == $past(structure_select))
		else $error("identify answer missing");
	a_ns_blank: assert property (id_req && !structure_select |=> id_data == 8'h00)
		else $error("namespace byte not blank");
	a_resv_bytes: assert property (ctl && id_byte_index inside {[78:255]} |=> id_data == 8'h00)
		else $error("reserved byte not zero");
	a_link_bits: assert property (ctl && id_byte_index == SB_MULTI |=> id_data[7:1] == 7'h00)
		else $error("link byte reserved bits set");
	a_admin_resv: assert property (ctl && id_byte_index == SB_ADMIN_HI |=> id_data == 8'h00)
		else $error("admin high byte not zero");
	a_fw_slots: assert property (ctl && id_byte_index == SB_FIRMWARE |=> id_data[7:4] == 4'h0 && id_data[3:1] != 3'h0)
		else $error("firmware slot field bad");
	a_log_resv: assert property (ctl && id_byte_index == SB_LOG_ATTR |=> id_data[7:1] == 7'h00)
		else $error("log attribute reserved bits set");
	// ==========================================
	// Size check answers; the smallest nonzero limit is 8192 bytes
	a_chk_answer: assert property (chk_req |=> chk_done)
		else $error("size check answer missing");
	a_abort_code: assert property (chk_done |-> (chk_abort ? chk_status == STATUS_INVALID_FIELD : chk_status == STATUS_OK))
		else $error("abort status mismatch");
	a_small_ok: assert property (chk_req && chk_data_bytes <= 32'd8192 && !(chk_meta_interleaved && chk_meta_bytes != 32'h0) |=> !chk_abort)
		else $error("small transfer aborted");
endmodule

bind capability_report controller_capability_report_chk i_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .id_req(id_req), .structure_select(structure_select),
	.id_byte_index(id_byte_index), .id_ack(id_ack), .id_is_controller(id_is_controller), .id_data(id_data),
	.chk_req(chk_req), .chk_data_bytes(chk_data_bytes), .chk_meta_bytes(chk_meta_bytes),
	.chk_meta_interleaved(chk_meta_interleaved), .chk_done(chk_done), .chk_abort(chk_abort),
	.chk_status(chk_status)
);
`default_nettype wire

// ---- tb/controller_capability_report_tb_top.sv ----
// Self-checking bench for the capability report block
`timescale 1ns/1ps
`default_nettype none

module controller_capability_report_tb_top
	import cap_report_pkg::*;
;
	logic sys_clk = 1'b0, rst_n = 1'b0, irq;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic id_req, structure_select, chk_req, chk_meta_interleaved, id_ack, id_is_controller;
	logic chk_done, chk_abort, irq_look = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [9:0] id_byte_index;
	logic [31:0] chk_data_bytes, chk_meta_bytes, lfsr = 32'h39b0_a460, d, m;
	logic [7:0] id_data, chk_status;
	logic [33:0] exp_q[$];
	int n_errors = 0, samples_checked = 0, cycles = 0;

	always #2.5 sys_clk = ~sys_clk;

	capability_report i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.id_req(id_req), .structure_select(structure_select), .id_byte_index(id_byte_index),
		.id_ack(id_ack), .id_is_controller(id_is_controller), .id_data(id_data), .chk_req(chk_req),
		.chk_data_bytes(chk_data_bytes), .chk_meta_bytes(chk_meta_bytes),
		.chk_meta_interleaved(chk_meta_interleaved), .chk_done(chk_done), .chk_abort(chk_abort),
		.chk_status(chk_status), .irq(irq)
	);
	host_model i_host (
		.sys_clk(sys_clk), .id_req(id_req), .structure_select(structure_select),
		.id_byte_index(id_byte_index), .chk_req(chk_req), .chk_data_bytes(chk_data_bytes),
		.chk_meta_bytes(chk_meta_bytes), .chk_meta_interleaved(chk_meta_interleaved)
	);

	// ==========================================
	// Compare and report
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp(input logic [33:0] got);
		logic [33:0] e;
		e = (exp_q.size() != 0) ? exp_q.pop_front() : ~got;
		samples_checked++;
		if (got !== e) begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, e);
		end
	endtask
	task automatic results();
		if (exp_q.size() != 0) begin
			n_errors++;
			$display("Error %0t: %0d answers never came", $time, exp_q.size());
		end
		if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Monitor: values read right after the edge are those the edge sampled
	always @(posedge sys_clk) begin
		if (id_ack) cmp({25'h0, id_is_controller, id_data});
		if (chk_done) cmp({25'h0, chk_abort, chk_status});
		if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) cmp({32'h0, s_axi_bresp});
		if (irq_look) cmp({33'h0, irq});
	end
	// A hang counts as a mismatch
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end

	// ==========================================
	// Drivers; each records the answer it expects
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] r);
		exp_q.push_back({32'h0, r});
		@(posedge sys_clk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		s_axi_wdata <= ~wd;
		s_axi_awaddr <= ~s_axi_awaddr;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge sys_clk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		s_axi_araddr <= ~s_axi_araddr;
	endtask
	task automatic ident(input logic [9:0] i, input logic s, input logic [7:0] e);
		exp_q.push_back({25'h0, s, s ? e : 8'h00});
		i_host.identify(i, s);
	endtask
	task automatic size_chk(input logic [31:0] dd, mm, input logic il, ab);
		exp_q.push_back({25'h0, ab, ab ? STATUS_INVALID_FIELD : STATUS_OK});
		i_host.check(dd, mm, il);
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge sys_clk);
		exp_q.push_back({33'h0, e});
		irq_look <= 1'b1;
		@(posedge sys_clk);
		irq_look <= 1'b0;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		axi_rd(OFS_VENDOR_ID, {10'h0, RST_VENDOR_ID});
		axi_rd(OFS_LINK_XFER, {14'h0, RST_PAGE_CAP, RST_EXPONENT, 8'h00});
		axi_rd(OFS_ADMIN, {31'h0, RST_ADMIN});
		axi_rd(OFS_LIMITS, {18'h0, RST_EVENT_LIM, RST_ABORT_LIM});
		axi_rd(OFS_FW_LOG, {30'h0, RST_FW_SLOTS, 1'b0});
		axi_rd(OFS_IRQ_MASK, 34'h0);
		axi_rd(8'h40, {RESP_SLVERR, 32'h0});
		ident(SB_VENDOR_LO, 1'b1, RST_VENDOR_ID[7:0]);
		ident(SB_VENDOR_MI, 1'b1, RST_VENDOR_ID[15:8]);
		ident(SB_VENDOR_HI, 1'b1, RST_VENDOR_ID[23:16]);
		ident(SB_MULTI, 1'b1, 8'h00);
		ident(SB_EXPONENT, 1'b1, RST_EXPONENT);
		ident(SB_EXPONENT, 1'b0, 8'h00);
		ident(10'd78, 1'b1, 8'h00);
		ident(10'd255, 1'b1, 8'h00);
		ident(SB_ADMIN_HI, 1'b1, 8'h00);
		ident(SB_ABORT, 1'b1, RST_ABORT_LIM);
		ident(SB_EVENT, 1'b1, RST_EVENT_LIM);
		ident(SB_FIRMWARE, 1'b1, {4'h0, RST_FW_SLOTS, 1'b0});
		ident(SB_LOG_ATTR, 1'b1, 8'h00);
		// Sticky status, read clears, masked interrupt
		axi_rd(OFS_IRQ_STATUS, {32'h0, 2'b10});
		axi_rd(OFS_IRQ_STATUS, 34'h0);
		axi_wr(OFS_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
		axi_wr(OFS_LINK_XFER, 32'h0000_0101, RESP_OKAY);
		ident(SB_MULTI, 1'b1, 8'h01);
		ident(SB_EXPONENT, 1'b1, 8'h01);
		irq_is(1'b0);
		size_chk(32'd8192, 32'd0, 1'b0, 1'b0);
		size_chk(32'd8193, 32'd0, 1'b0, 1'b1);
		irq_is(1'b1);
		size_chk(32'd8000, 32'd193, 1'b1, 1'b1);
		size_chk(32'd8000, 32'd193, 1'b0, 1'b0);
		axi_rd(OFS_IRQ_STATUS, {32'h0, 2'b11});
		irq_is(1'b0);
		axi_wr(OFS_ABORT_COUNT, 32'h0000_0000, RESP_OKAY);
		axi_rd(OFS_ABORT_COUNT, {2'b00, 32'd2});
		axi_wr(OFS_LINK_XFER, 32'h0001_0100, RESP_OKAY);
		size_chk(32'd16384, 32'd0, 1'b0, 1'b0);
		size_chk(32'd16385, 32'd0, 1'b0, 1'b1);
		axi_wr(OFS_LINK_XFER, 32'h0000_0000, RESP_OKAY);
		size_chk(32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b1, 1'b0);
		axi_wr(OFS_FW_LOG, 32'h0000_010F, RESP_OKAY);
		ident(SB_FIRMWARE, 1'b1, 8'h0F);
		ident(SB_LOG_ATTR, 1'b1, 8'h01);
		axi_wr(OFS_FW_LOG, 32'h0000_0000, RESP_OKAY);
		ident(SB_FIRMWARE, 1'b1, 8'h02);
		for (int k = 0; k < 8; k++) begin
			axi_wr(OFS_ADMIN, k, RESP_OKAY);
			ident(SB_ADMIN_LO, 1'b1, {5'h0, k[2:0] & {IMPL_FW_UPDATE, IMPL_FORMAT, IMPL_SECURITY}});
		end
		axi_wr(OFS_LIMITS, 32'h0000_0704, RESP_OKAY);
		ident(SB_ABORT, 1'b1, 8'h04);
		ident(SB_EVENT, 1'b1, 8'h07);
		// Byte strobes: only the event limit byte lands
		s_axi_wstrb <= 4'h2;
		axi_wr(OFS_LIMITS, 32'h0000_0900, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		ident(SB_EVENT, 1'b1, 8'h09);
		ident(SB_ABORT, 1'b1, 8'h04);
		axi_wr(OFS_VENDOR_ID, 32'hFFAB_CDEF, RESP_OKAY);
		axi_rd(OFS_VENDOR_ID, {2'b00, 32'h00AB_CDEF});
		ident(SB_VENDOR_HI, 1'b1, 8'hAB);
		axi_wr(8'h40, 32'h0000_0001, RESP_SLVERR);
		// Mid-run reset brings the fields back to their reset values
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		axi_rd(OFS_LIMITS, {18'h0, RST_EVENT_LIM, RST_ABORT_LIM});
		ident(SB_VENDOR_HI, 1'b1, RST_VENDOR_ID[23:16]);
		// Random sizes around an 8192 byte limit, random blank bytes
		axi_wr(OFS_LINK_XFER, 32'h0000_0100, RESP_OKAY);
		for (int k = 0; k < 24; k++) begin
			lfsr = lfsr_next(lfsr);
			d = lfsr & 32'h0000_3FFF;
			m = {20'h0, lfsr[31:20]};
			size_chk(d, m, lfsr[5], (d + (lfsr[5] ? m : 32'h0)) > 32'd8192);
			ident({1'b1, lfsr[24:16]}, 1'b1, 8'h00);
		end
		repeat (4) @(posedge sys_clk);
		results();
	end
endmodule
`default_nettype wire

// ---- tb/host_model.sv ----
// Host side model issuing identify and size check requests
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input  wire logic        sys_clk,
	output var  logic        id_req,
	output var  logic        structure_select,
	output var  logic [9:0]  id_byte_index,
	output var  logic        chk_req,
	output var  logic [31:0] chk_data_bytes,
	output var  logic [31:0] chk_meta_bytes,
	output var  logic        chk_meta_interleaved
);
	// ==========================================
	// Idle values; released index and size fields show the inverse, not a stale copy
	initial begin
		id_req = 1'b0;
		structure_select = 1'b1;
		id_byte_index = 10'h000;
		chk_req = 1'b0;
		chk_data_bytes = 32'h0;
		chk_meta_bytes = 32'h0;
		chk_meta_interleaved = 1'b0;
	end

	// One byte request, one cycle pulse
	task automatic identify(input logic [9:0] idx, input logic sel);
		@(posedge sys_clk);
		id_req <= 1'b1;
		structure_select <= sel;
		id_byte_index <= idx;
		@(posedge sys_clk);
		id_req <= 1'b0;
		id_byte_index <= ~idx;
	endtask

	// Oversized commands only when the caller asks for them
	task automatic check(input logic [31:0] d, m, input logic il);
		@(posedge sys_clk);
		chk_req <= 1'b1;
		chk_data_bytes <= d;
		chk_meta_bytes <= m;
		chk_meta_interleaved <= il;
		@(posedge sys_clk);
		chk_req <= 1'b0;
		chk_data_bytes <= ~d;
		chk_meta_bytes <= ~m;
	endtask
endmodule
`default_nettype wire
